// [mcec_code_shifter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mcec_regs.svh"

// repeats the low N bits of the code, most significant of them first
module mcec_code_shifter
    import mcec_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic enable,
    input wire logic bit_en,
    input wire logic [7:0] code,
    input wire logic [1:0] len,
    output logic code_bit
);

    logic [2:0] idx;
    logic [2:0] next_idx;
    logic next_code_bit;
    logic [2:0] top;
    logic [2:0] cur;

    always_comb begin
        top = 3'(len) + 3'(`MCEC_MIN_CODE_LEN - 1);
        // a shortened length never reaches above the new top bit
        cur = (idx > top) ? top : idx;
        next_idx = idx;
        next_code_bit = code_bit;
        if (!enable) begin
            next_idx = top;
            next_code_bit = 1'b0;
        end else if (bit_en) begin
            next_code_bit = code[cur];
            next_idx = (cur == 3'h0) ? top : cur - 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            idx <= 3'h4;
            code_bit <= 1'b0;
        end else begin
            idx <= next_idx;
            code_bit <= next_code_bit;
        end
    end

endmodule

`default_nettype wire

// [mcec_err_counter.sv]
`timescale 1ns/10ps
`default_nettype none

// 16-bit error counter, saturating, with transfer-and-clear
module mcec_err_counter
    import mcec_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire mcec_err_sel_type sel,
    input wire mcec_rx_err_type rx_err,
    input wire logic transfer,
    output logic [WIDTH-1:0] result
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] next_result;
    logic [1:0] inc;
    logic [WIDTH:0] sum;

    always_comb begin
        case (sel)
            MCEC_SEL_PATTERN: inc = {1'b0, rx_err.pattern_error};
            MCEC_SEL_ZERO_RUN: inc = {1'b0, rx_err.excess_zero};
            MCEC_SEL_VIOLATION: inc = {1'b0, rx_err.code_violation};
            MCEC_SEL_VIOL_ZERO:
                inc = 2'(rx_err.code_violation) + 2'(rx_err.excess_zero);
            default: inc = 2'h0;
        endcase
        next_result = result;
        if (transfer) begin
            // events in the transfer cycle start the new count
            next_result = count;
            sum = {{(WIDTH-1){1'b0}}, inc};
        end else begin
            sum = {1'b0, count} + {{(WIDTH-1){1'b0}}, inc};
        end
        next_count = sum[WIDTH] ? '1 : sum[WIDTH-1:0];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            count <= '0;
            result <= '0;
        end else begin
            count <= next_count;
            result <= next_result;
        end
    end

endmodule

`default_nettype wire

// [mcec_maint_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "mcec_regs.svh"

module mcec_maint_ctrl
    import mcec_pkg::*;
#(
    parameter int REPORT_CYCLES = `MCEC_REPORT_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire mcec_tx_pattern_sel_type tx_pattern_sel,
    input wire logic tx_bit_en,
    output logic tx_loop_active,
    output logic tx_loop_code,
    output logic violation_insert,
    output logic pattern_error_insert,
    output mcec_rx_code_type rx_activate_code,
    output mcec_rx_code_type rx_deactivate_code,
    output logic zero_run_rule_sel,
    input wire mcec_rx_err_type rx_err,
    output logic report_tick
);

    logic [7:0] code_len;
    logic [7:0] tx_code;
    logic [7:0] act_code;
    logic [7:0] deact_code;
    logic [7:0] err_ctrl;
    logic [7:0] next_code_len;
    logic [7:0] next_tx_code;
    logic [7:0] next_act_code;
    logic [7:0] next_deact_code;
    logic [7:0] next_err_ctrl;
    logic [7:0] next_rdata;
    logic [15:0] count_result;

    // register writes
    always_comb begin
        next_code_len = code_len;
        next_tx_code = tx_code;
        next_act_code = act_code;
        next_deact_code = deact_code;
        next_err_ctrl = err_ctrl;
        if (wr_en) begin
            case (addr)
                `MCEC_ADDR_CODE_LEN:
                    next_code_len = wdata & `MCEC_CODE_LEN_MASK;
                `MCEC_ADDR_TX_CODE: next_tx_code = wdata;
                `MCEC_ADDR_RX_ACT_CODE: next_act_code = wdata;
                `MCEC_ADDR_RX_DEACT_CODE: next_deact_code = wdata;
                `MCEC_ADDR_ERR_CTRL:
                    next_err_ctrl = wdata & `MCEC_ERR_CTRL_MASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            code_len <= `MCEC_RST_CODE_LEN;
            tx_code <= `MCEC_RST_TX_CODE;
            act_code <= `MCEC_RST_RX_ACT_CODE;
            deact_code <= `MCEC_RST_RX_DEACT_CODE;
            err_ctrl <= `MCEC_RST_ERR_CTRL;
        end else begin
            code_len <= next_code_len;
            tx_code <= next_tx_code;
            act_code <= next_act_code;
            deact_code <= next_deact_code;
            err_ctrl <= next_err_ctrl;
        end
    end

    // register reads, unmapped addresses read zero
    always_comb begin
        next_rdata = rdata;
        if (rd_en) begin
            case (addr)
                `MCEC_ADDR_CODE_LEN: next_rdata = code_len;
                `MCEC_ADDR_TX_CODE: next_rdata = tx_code;
                `MCEC_ADDR_RX_ACT_CODE: next_rdata = act_code;
                `MCEC_ADDR_RX_DEACT_CODE: next_rdata = deact_code;
                `MCEC_ADDR_ERR_CTRL: next_rdata = err_ctrl;
                `MCEC_ADDR_COUNT_LOW: next_rdata = count_result[7:0];
                `MCEC_ADDR_COUNT_HIGH: next_rdata = count_result[15:8];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // rising-edge detection of the single-shot control bits
    logic viol_prev;
    logic tx_pattern_sel_prev;
    logic xfer_prev;
    logic next_violation_insert;
    logic next_pattern_error_insert;
    logic manual_xfer;
    logic next_manual_xfer;

    always_comb begin
        next_violation_insert = err_ctrl[`MCEC_BIT_VIOL_INJ]
            & ~viol_prev;
        next_pattern_error_insert = err_ctrl[`MCEC_BIT_TX_PATTERN_SEL_INJ]
            & ~tx_pattern_sel_prev;
        // a held transfer bit makes no further transfers
        next_manual_xfer = err_ctrl[`MCEC_BIT_TRANSFER] & ~xfer_prev
            & ~err_ctrl[`MCEC_BIT_MODE];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            viol_prev <= 1'b0;
            tx_pattern_sel_prev <= 1'b0;
            xfer_prev <= 1'b0;
            violation_insert <= 1'b0;
            pattern_error_insert <= 1'b0;
            manual_xfer <= 1'b0;
        end else begin
            viol_prev <= err_ctrl[`MCEC_BIT_VIOL_INJ];
            tx_pattern_sel_prev <= err_ctrl[`MCEC_BIT_TX_PATTERN_SEL_INJ];
            xfer_prev <= err_ctrl[`MCEC_BIT_TRANSFER];
            violation_insert <= next_violation_insert;
            pattern_error_insert <= next_pattern_error_insert;
            manual_xfer <= next_manual_xfer;
        end
    end

    // automatic report interval divider
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic next_report_tick;

    always_comb begin
        next_div_cnt = div_cnt;
        next_report_tick = 1'b0;
        if (!err_ctrl[`MCEC_BIT_MODE]) begin
            next_div_cnt = 32'h0;
        end else if (div_cnt >= 32'(REPORT_CYCLES - 1)) begin
            next_div_cnt = 32'h0;
            next_report_tick = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt <= 32'h0;
            report_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            report_tick <= next_report_tick;
        end
    end

    mcec_err_counter #(
        .WIDTH(16)
    ) u_counter (
        .mclk(mclk),
        .srst(srst),
        .sel(mcec_err_sel_type'(err_ctrl[`MCEC_SEL_LSB +: 2])),
        .rx_err(rx_err),
        .transfer(manual_xfer | report_tick),
        .result(count_result)
    );

    always_comb begin
        tx_loop_active = (tx_pattern_sel == MCEC_TX_PATTERN_SEL_LOOP_CODE);
        zero_run_rule_sel = err_ctrl[`MCEC_BIT_ZERO_RULE];
        rx_activate_code.code = act_code;
        rx_activate_code.len = code_len[`MCEC_ACT_LEN_LSB +: 2];
        rx_deactivate_code.code = deact_code;
        rx_deactivate_code.len = code_len[`MCEC_DEACT_LEN_LSB +: 2];
    end

    mcec_code_shifter u_shifter (
        .mclk(mclk),
        .srst(srst),
        .enable(tx_loop_active),
        .bit_en(tx_bit_en),
        .code(tx_code),
        .len(code_len[`MCEC_TX_LEN_LSB +: 2]),
        .code_bit(tx_loop_code)
    );

endmodule

`default_nettype wire

// [mcec_maint_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module mcec_maint_monitor
    import mcec_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire mcec_tx_pattern_sel_type tx_pattern_sel,
    input wire logic tx_loop_active,
    input wire logic tx_loop_code,
    input wire logic violation_insert,
    input wire logic pattern_error_insert,
    input wire mcec_rx_code_type rx_activate_code,
    input wire mcec_rx_code_type rx_deactivate_code,
    input wire logic zero_run_rule_sel,
    input wire logic report_tick
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // mirror of the inject bits to see rising writes
    logic [1:0] inj;
    wire logic ctl_wr = wr_en && addr == 8'h13;
    wire logic vr = ctl_wr && wdata[6] && !inj[1];
    wire logic pr = ctl_wr && wdata[5] && !inj[0];
    always_ff @(posedge mclk) begin
        if (srst)
            inj <= 2'h0;
        else if (ctl_wr)
            inj <= wdata[6:5];
    end
    sequence viol_pulse;
        violation_insert ##1 !violation_insert;
    endsequence
    sequence tx_pattern_sel_pulse;
        pattern_error_insert ##1 !pattern_error_insert;
    endsequence
    viol_once_a: assert property (vr |-> ##2 viol_pulse)
        else $error("violation pulse missing");
    viol_cause_a: assert property (violation_insert |-> $past(vr, 2))
        else $error("violation pulse without rise");
    tx_pattern_sel_once_a: assert property (pr |-> ##2 tx_pattern_sel_pulse)
        else $error("pattern error pulse missing");
    tx_pattern_sel_cause_a: assert property (
        pattern_error_insert |-> $past(pr, 2))
        else $error("pattern error pulse without rise");
    loop_flag_a: assert property (tx_loop_active ==
        (tx_pattern_sel == MCEC_TX_PATTERN_SEL_LOOP_CODE))
        else $error("loop active flag wrong");
    loop_idle_a: assert property (
        !tx_loop_active ##1 !tx_loop_active |-> !tx_loop_code)
        else $error("loop bit while idle");
    zero_rule_a: assert property (ctl_wr |=>
        zero_run_rule_sel == $past(wdata[4])) else $error("zero rule sel");
    act_code_a: assert property (wr_en && addr == 8'h11 |=>
        rx_activate_code.code == $past(wdata)) else $error("activate code");
    deact_code_a: assert property (wr_en && addr == 8'h12 |=>
        rx_deactivate_code.code == $past(wdata)) else $error("deactivate code");
    code_len_a: assert property (wr_en && addr == 8'h0F |=>
        rx_activate_code.len == $past(wdata[3:2]) &&
        rx_deactivate_code.len == $past(wdata[1:0])) else $error("code len");
    tick_gap_a: assert property (report_tick |=> !report_tick [*8])
        else $error("report ticks too close");
endmodule
bind mcec_maint_ctrl mcec_maint_monitor mon (.mclk, .srst, .addr, .wr_en,
    .wdata, .tx_pattern_sel, .tx_loop_active, .tx_loop_code,
    .violation_insert, .pattern_error_insert, .rx_activate_code,
    .rx_deactivate_code, .zero_run_rule_sel, .report_tick);
`default_nettype wire

// [mcec_pkg.sv]
package mcec_pkg;

    typedef enum logic [1:0] {
        MCEC_SEL_PATTERN = 2'h0,
        MCEC_SEL_ZERO_RUN = 2'h1,
        MCEC_SEL_VIOLATION = 2'h2,
        MCEC_SEL_VIOL_ZERO = 2'h3
    } mcec_err_sel_type;

    typedef enum logic [1:0] {
        MCEC_TX_PATTERN_SEL_NORMAL = 2'h0,
        MCEC_TX_PATTERN_SEL_ONES = 2'h1,
        MCEC_TX_PATTERN_SEL_PRBS = 2'h2,
        MCEC_TX_PATTERN_SEL_LOOP_CODE = 2'h3
    } mcec_tx_pattern_sel_type;

    // receive error events, one-cycle pulses each
    typedef struct packed {
        logic pattern_error;
        logic excess_zero;
        logic code_violation;
    } mcec_rx_err_type;

    // receive in-band code with its length select
    typedef struct packed {
        logic [7:0] code;
        logic [1:0] len;
    } mcec_rx_code_type;

endpackage

// [mcec_regs.svh]
`ifndef MCEC_REGS_SVH
`define MCEC_REGS_SVH

// register offsets on the microprocessor port
`define MCEC_ADDR_CODE_LEN 8'h0F
`define MCEC_ADDR_TX_CODE 8'h10
`define MCEC_ADDR_RX_ACT_CODE 8'h11
`define MCEC_ADDR_RX_DEACT_CODE 8'h12
`define MCEC_ADDR_ERR_CTRL 8'h13
`define MCEC_ADDR_COUNT_LOW 8'h1E
`define MCEC_ADDR_COUNT_HIGH 8'h1F

// reset values
`define MCEC_RST_CODE_LEN 8'h01
`define MCEC_RST_TX_CODE 8'h01
`define MCEC_RST_RX_ACT_CODE 8'h01
`define MCEC_RST_RX_DEACT_CODE 8'h09
`define MCEC_RST_ERR_CTRL 8'h00

// loopback_code_length_ctrl fields
`define MCEC_TX_LEN_LSB 4
`define MCEC_ACT_LEN_LSB 2
`define MCEC_DEACT_LEN_LSB 0
`define MCEC_CODE_LEN_MASK 8'h3F

// error_insert_count_ctrl fields
`define MCEC_BIT_VIOL_INJ 6
`define MCEC_BIT_TX_PATTERN_SEL_INJ 5
`define MCEC_BIT_ZERO_RULE 4
`define MCEC_SEL_LSB 2
`define MCEC_BIT_MODE 1
`define MCEC_BIT_TRANSFER 0
`define MCEC_ERR_CTRL_MASK 8'h7F

// shortest in-band code length
`define MCEC_MIN_CODE_LEN 5

// automatic report interval
`define MCEC_CLK_HZ 50000000
`define MCEC_REPORT_PERIOD_MS 1000
`define MCEC_REPORT_CYCLES (`MCEC_CLK_HZ / 1000 * `MCEC_REPORT_PERIOD_MS)

`endif

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
    import mcec_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, bit_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    mcec_tx_pattern_sel_type psel = MCEC_TX_PATTERN_SEL_NORMAL;
    mcec_rx_err_type rx_err = '0;
    mcec_rx_code_type acode, dcode;
    logic act, lcode, vins, pins, zsel, tick;
    logic [15:0] nv = 16'h0000, np = 16'h0000;
    int n_mismatch = 0, checks_done = 0;
    // rows: address, write data, read back
    logic [23:0] rows [7] = '{24'h0FFF3F, 24'h10A5A5, 24'h115A5A,
        24'h12C3C3, 24'h139010, 24'h1E5500, 24'h207700};
    logic [15:0] rrows [5] = '{16'h0F01, 16'h1001, 16'h1101, 16'h1209,
        16'h1300};
    logic [15:0] cnt_exp [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0006};
    mcec_maint_ctrl #(.REPORT_CYCLES(20)) dut (.mclk(mclk), .srst(srst),
        .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
        .rdata(rdata), .tx_pattern_sel(psel), .tx_bit_en(bit_en),
        .tx_loop_active(act), .tx_loop_code(lcode), .violation_insert(vins),
        .pattern_error_insert(pins), .rx_activate_code(acode),
        .rx_deactivate_code(dcode), .zero_run_rule_sel(zsel),
        .rx_err(rx_err), .report_tick(tick));
    initial begin
        forever #10 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        nv <= nv + {15'h0000, vins};
        np <= np + {15'h0000, pins};
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 chk({8'h00, rdata}, e);
    endtask
    task wtick(output int w);
        w = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk);
            if (tick === 1'b1) begin
                w = i + 1;
                return;
            end
        end
        n_mismatch++;
        $display("MISMATCH t=%0t no report tick", $time);
        print_verdict;
    endtask
    initial begin
        logic [7:0] tc;
        int n, b, w;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], 16'(rows[i][7:0]));
        end
        chk(16'(zsel), 16'h0001);
        $display("table test done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        foreach (rrows[i])
            rdc(rrows[i][15:8], 16'(rrows[i][7:0]));
        chk({6'h00, acode}, {6'h00, 8'h01, 2'h0});
        chk({6'h00, dcode}, {6'h00, 8'h09, 2'h1});
        chk(16'(zsel), 16'h0000);
        $display("reset test done");
        for (int s = 0; s < 4; s++) begin
            wr(8'h13, {4'h0, s[1:0], 2'h0});
            @(posedge mclk);
            // 1 pattern, 2 zero-run and 4 violation events
            rx_err <= mcec_rx_err_type'(3'h4);
            @(posedge mclk);
            rx_err <= mcec_rx_err_type'(3'h2);
            repeat (2) @(posedge mclk);
            rx_err <= mcec_rx_err_type'(3'h1);
            repeat (4) @(posedge mclk);
            rx_err <= '0;
            wr(8'h13, {4'h0, s[1:0], 2'h1});
            repeat (3) @(posedge mclk);
            rdc(8'h1E, cnt_exp[s]);
            rdc(8'h1F, 16'h0000);
        end
        $display("count test done");
        wr(8'h13, 8'h0A);
        wtick(w);
        wtick(w);
        chk(16'(w), 16'h0014);
        @(posedge mclk);
        rx_err <= mcec_rx_err_type'(3'h1);
        repeat (2) @(posedge mclk);
        rx_err <= '0;
        wr(8'h13, 8'h0B);
        rdc(8'h1E, 16'h0000);
        wtick(w);
        repeat (3) @(posedge mclk);
        rdc(8'h1E, 16'h0002);
        wr(8'h13, 8'h00);
        $display("auto test done");
        wr(8'h13, 8'h60);
        wr(8'h13, 8'h60);
        repeat (4) @(posedge mclk);
        chk(nv, 16'h0001);
        chk(np, 16'h0001);
        wr(8'h13, 8'h00);
        wr(8'h13, 8'h60);
        repeat (4) @(posedge mclk);
        chk(nv, 16'h0002);
        chk(np, 16'h0002);
        $display("inject test done");
        tc = 8'h8D;
        wr(8'h10, tc);
        for (int k = 0; k < 4; k += 3) begin
            n = k + 5;
            wr(8'h0F, {2'h0, k[1:0], 4'h0});
            @(posedge mclk);
            psel <= MCEC_TX_PATTERN_SEL_LOOP_CODE;
            for (int i = 0; i < 12; i++) begin
                b = n - 1 - i % n;
                @(posedge mclk);
                bit_en <= 1'b1;
                @(posedge mclk);
                bit_en <= 1'b0;
                #1 chk(16'(lcode), 16'(tc[b]));
            end
            @(posedge mclk);
            psel <= MCEC_TX_PATTERN_SEL_NORMAL;
            repeat (2) @(posedge mclk);
            #1 chk({15'h0000, lcode}, 16'h0000);
        end
        $display("loop code test done");
        print_verdict;
    end
endmodule
`default_nettype wire
